// ===== adcu_defines.svh
// register map, field positions, reset values and timing constants of the converter control
`ifndef ADCU_DEFINES_SVH
`define ADCU_DEFINES_SVH

`define ADCU_IDX_REFSEL 6'h1B
`define ADCU_IDX_CTRL 6'h1D
`define ADCU_IDX_RESULT 6'h1E
`define ADCU_WORD_LSB 2
`define ADCU_WORD_MSB 7
`define ADCU_ADDR_W 8
`define ADCU_REFSEL_BIT 6
`define ADCU_REFSEL_RST 1'h1
`define ADCU_CTRL_RST 8'h80
`define ADCU_RESULT_RST 8'h00
`define ADCU_NUM_CH 6
`define ADCU_RES_W 8
`define ADCU_CH_LOW_REF 3'h6
`define ADCU_CH_HIGH_REF 3'h7
`define ADCU_SAR_MSB 8'h80
`define ADCU_RESP_OKAY 2'h0
`define ADCU_RESP_SLVERR 2'h2
`define ADCU_SYS_CLK_KHZ 100000
`define ADCU_CONV_FAST_KHZ 6000
`define ADCU_DIV_BASE (`ADCU_SYS_CLK_KHZ / `ADCU_CONV_FAST_KHZ)

`endif

// ===== adcu_pkg.sv
// types shared by the converter control files
package adcu_pkg;

  typedef struct packed {
    logic done_n;
    logic enable;
    logic start;
    logic [1:0] clk_sel;
    logic [2:0] chan;
  } adcu_ctrl_t;

  typedef struct packed {
    logic power;
    logic ref_internal;
    logic [2:0] chan;
    logic [7:0] dac_code;
  } adcu_analog_t;

  typedef enum logic {
    SAR_IDLE,
    SAR_TRIAL
  } adcu_sar_state_t;

endpackage

// ===== adcu_sar.sv
// successive approximation sequencer: one bit trial per conversion clock tick
`timescale 1ns/1ps
`include "adcu_defines.svh"

module adcu_sar (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clr,
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic i_cmp_above,
  output logic [7:0] o_dac_code,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_result
);
  adcu_pkg::adcu_sar_state_t state_reg;
  logic [7:0] code_reg;
  logic [2:0] idx_reg;
  logic done_reg;
  logic [7:0] result_reg;
  logic [7:0] trial_kept;
  logic last_trial;

  // drop the trial bit when the input sits below the trial level
  assign trial_kept = i_cmp_above ? code_reg : (code_reg & ~(8'h01 << idx_reg));
  assign last_trial = (state_reg == adcu_pkg::SAR_TRIAL) && i_tick && (idx_reg == 3'h0);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_clr) begin
      state_reg <= adcu_pkg::SAR_IDLE;
    end else begin
      case (state_reg)
        adcu_pkg::SAR_IDLE: begin
          if (i_start) begin
            state_reg <= adcu_pkg::SAR_TRIAL;
          end
        end
        adcu_pkg::SAR_TRIAL: begin
          if (last_trial) begin
            state_reg <= adcu_pkg::SAR_IDLE;
          end
        end
        default: begin
          state_reg <= adcu_pkg::SAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_clr) begin
      code_reg <= `ADCU_RESULT_RST;
      idx_reg <= 3'h7;
    end else if (state_reg == adcu_pkg::SAR_IDLE && i_start) begin
      code_reg <= `ADCU_SAR_MSB;
      idx_reg <= 3'h7;
    end else if (state_reg == adcu_pkg::SAR_TRIAL && i_tick) begin
      if (idx_reg == 3'h0) begin
        code_reg <= trial_kept;
      end else begin
        code_reg <= trial_kept | (8'h01 << (idx_reg - 3'h1));
        idx_reg <= idx_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_clr) begin
      done_reg <= 1'h0;
      result_reg <= `ADCU_RESULT_RST;
    end else begin
      done_reg <= last_trial;
      if (last_trial) begin
        result_reg <= trial_kept;
      end
    end
  end

  assign o_dac_code = code_reg;
  assign o_busy = (state_reg == adcu_pkg::SAR_TRIAL);
  assign o_done = done_reg;
  assign o_result = result_reg;

  sequence seq_sar_launch;
    (state_reg == adcu_pkg::SAR_IDLE) && i_start && !i_clr;
  endsequence

  sequence seq_sar_last;
    last_trial && !i_clr;
  endsequence

  AST_SAR_LAUNCH: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_01
    seq_sar_launch |=> o_busy && (o_dac_code == `ADCU_SAR_MSB) && (idx_reg == 3'h7))
    else $error("conversion did not open with the top bit trial");

  AST_SAR_FINISH: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_09
    seq_sar_last |=> o_done && !o_busy && (o_result == $past(trial_kept)))
    else $error("last trial did not deliver the result");

endmodule // adcu_sar

// ===== adcu_top.sv
// converter control: AXI4-Lite registers, conversion clock divider, start sequencing, pin sharing
//
// Functional notes
// RULE_01 - six inputs, eight-bit result
// RULE_02 - bits 2:0 pick input or reference
// RULE_03 - inputs share port B pins 0 to 5
// RULE_04 - bits 4:3 pick conversion clock rate
// RULE_05 - start pulse high then low begins conversion
// RULE_06 - start rising resets converter, clears result
// RULE_07 - bit 6 powers converter on or off
// RULE_08 - bit 7 reads low when done
// RULE_09 - result readable in result register
// RULE_10 - range runs low reference to high
// RULE_11 - unused analog pins stay general purpose
// RULE_12 - build option removes converter entirely; here the converter stays instantiated, held off with enable stuck clear
// RULE_13 - reference select bit chooses supply rails
// RULE_14 - software enables, pulses start, polls done
`timescale 1ns/1ps
`include "adcu_defines.svh"

module adcu_top #(
  parameter bit ADC_PRESENT = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_cmp_above,
  output adcu_pkg::adcu_analog_t o_analog,
  output logic [7:0] o_portb_analog_en
);
  adcu_pkg::adcu_ctrl_t ctrl_reg;
  adcu_pkg::adcu_ctrl_t wr_ctrl_val;
  logic refsel_reg;
  logic [7:0] result_reg;
  logic aw_have_reg;
  logic [5:0] aw_word_reg;
  logic w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_limit;
  logic [7:0] portb_reg;
  logic [7:0] portb_next;
  logic [5:0] ar_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_fire;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_refsel;
  logic conv_on;
  logic conv_tick;
  logic start_rise;
  logic start_fall;
  logic sar_clr;
  logic sar_start;
  logic sar_busy;
  logic sar_done;
  logic [7:0] sar_code;
  logic [7:0] sar_result;

  // ---------------- bus slave ----------------
  // one write and one read outstanding; address and data may arrive in either order
  assign o_awready = !aw_have_reg && !bvalid_reg;
  assign o_wready = !w_have_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_hit = (aw_word_reg == `ADCU_IDX_CTRL) || (aw_word_reg == `ADCU_IDX_RESULT) ||
                  (aw_word_reg == `ADCU_IDX_REFSEL);
  assign wr_ctrl = wr_fire && (aw_word_reg == `ADCU_IDX_CTRL) && w_strb_reg[0];
  assign wr_refsel = wr_fire && (aw_word_reg == `ADCU_IDX_REFSEL) && w_strb_reg[0];
  assign wr_ctrl_val = adcu_pkg::adcu_ctrl_t'(w_data_reg[7:0]);
  assign ar_word = i_araddr[`ADCU_WORD_MSB:`ADCU_WORD_LSB];

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      aw_have_reg <= 1'h0;
      aw_word_reg <= 6'h00;
    end else if (i_awvalid && o_awready) begin
      aw_have_reg <= 1'h1;
      aw_word_reg <= i_awaddr[`ADCU_WORD_MSB:`ADCU_WORD_LSB];
    end else if (wr_fire) begin
      aw_have_reg <= 1'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      w_have_reg <= 1'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_have_reg <= 1'h1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      bvalid_reg <= 1'h0;
      bresp_reg <= `ADCU_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'h1;
      bresp_reg <= wr_hit ? `ADCU_RESP_OKAY : `ADCU_RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_reg <= 1'h0;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'h1;
    case (ar_word)
      `ADCU_IDX_CTRL: begin
        rd_word[7:0] = ctrl_reg;
      end
      `ADCU_IDX_RESULT: begin
        rd_word[7:0] = result_reg; // RULE_09
      end
      `ADCU_IDX_REFSEL: begin
        rd_word[`ADCU_REFSEL_BIT] = refsel_reg;
      end
      default: begin
        rd_hit = 1'h0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rvalid_reg <= 1'h0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `ADCU_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_reg <= 1'h1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? `ADCU_RESP_OKAY : `ADCU_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_reg <= 1'h0;
    end
  end

  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // ---------------- control register ----------------
  // the build option ties the converter off: enable can never be set
  assign conv_on = ADC_PRESENT && ctrl_reg.enable; // RULE_12 RULE_07
  assign start_rise = wr_ctrl && wr_ctrl_val.start && !ctrl_reg.start; // RULE_06
  assign start_fall = wr_ctrl && !wr_ctrl_val.start && ctrl_reg.start; // RULE_05

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_reg <= adcu_pkg::adcu_ctrl_t'(`ADCU_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.chan <= wr_ctrl_val.chan; // RULE_02
        ctrl_reg.clk_sel <= wr_ctrl_val.clk_sel; // RULE_04
        ctrl_reg.start <= wr_ctrl_val.start;
        ctrl_reg.enable <= wr_ctrl_val.enable && ADC_PRESENT; // RULE_07 RULE_12
      end
      // a start edge aborts any running conversion, so its done event is void
      if (start_rise) begin
        ctrl_reg.done_n <= 1'h1; // RULE_06
      end else if (sar_done) begin
        ctrl_reg.done_n <= 1'h0; // RULE_08
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      refsel_reg <= `ADCU_REFSEL_RST;
    end else if (wr_refsel) begin
      refsel_reg <= w_data_reg[`ADCU_REFSEL_BIT]; // RULE_13
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || start_rise) begin
      result_reg <= `ADCU_RESULT_RST; // RULE_06
    end else if (sar_done) begin
      result_reg <= sar_result; // RULE_09
    end
  end

  // ---------------- conversion clock ----------------
  // 100 MHz does not divide to 6 MHz; the fastest setting runs a little above it
  assign div_limit = 8'((`ADCU_DIV_BASE << ctrl_reg.clk_sel) - 1); // RULE_04
  assign conv_tick = conv_on && (div_cnt_reg == div_limit);

  // restart at launch so the first trial gets a full period for the comparator to settle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !conv_on || start_rise || sar_start || conv_tick) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // comparator is an analog pin: synchronise before the sequencer reads it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cmp_meta_reg <= 1'h0;
      cmp_sync_reg <= 1'h0;
    end else begin
      cmp_meta_reg <= i_cmp_above;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  assign sar_clr = start_rise || !conv_on; // RULE_06 RULE_07
  assign sar_start = start_fall && conv_on; // RULE_05

  adcu_sar u_sar (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clr(sar_clr),
    .i_start(sar_start),
    .i_tick(conv_tick),
    .i_cmp_above(cmp_sync_reg),
    .o_dac_code(sar_code),
    .o_busy(sar_busy),
    .o_done(sar_done),
    .o_result(sar_result)
  );

  // ---------------- analog side and pin sharing ----------------
  assign o_analog.power = conv_on; // RULE_07
  assign o_analog.ref_internal = refsel_reg; // RULE_10 RULE_13
  assign o_analog.chan = ctrl_reg.chan; // RULE_02
  assign o_analog.dac_code = sar_code; // RULE_10

  // pins not claimed by the converter stay with the general purpose port
  genvar gi;
  generate
    for (gi = 0; gi < `ADCU_NUM_CH; gi = gi + 1) begin : g_chan
      assign portb_next[gi] = conv_on && (ctrl_reg.chan == 3'(gi)); // RULE_03 RULE_11
    end
  endgenerate
  assign portb_next[6] = conv_on && (!refsel_reg || ctrl_reg.chan == `ADCU_CH_LOW_REF); // RULE_11
  assign portb_next[7] = conv_on && (!refsel_reg || ctrl_reg.chan == `ADCU_CH_HIGH_REF); // RULE_11

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      portb_reg <= 8'h00;
    end else begin
      portb_reg <= portb_next;
    end
  end

  assign o_portb_analog_en = portb_reg;

  // ---------------- checks ----------------
  logic [7:0] tick_gap_reg;
  logic tick_gap_ok_reg;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !conv_on || wr_ctrl) begin
      tick_gap_reg <= 8'h00;
      tick_gap_ok_reg <= 1'h0;
    end else if (conv_tick) begin
      tick_gap_reg <= 8'h00;
      tick_gap_ok_reg <= 1'h1;
    end else begin
      tick_gap_reg <= tick_gap_reg + 8'h01;
    end
  end

  default clocking cb_main @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence seq_start_high;
    start_rise;
  endsequence

  sequence seq_start_low;
    start_fall && conv_on && !sar_busy;
  endsequence

  AST_START_RISE_CLEARS: assert property (seq_start_high |=> // RULE_06
    (result_reg == `ADCU_RESULT_RST) && ctrl_reg.done_n && !sar_busy)
    else $error("start rising edge did not reset converter and result");

  AST_PULSE_BEGINS: assert property (seq_start_low |=> sar_busy ##1 sar_busy) // RULE_05
    else $error("complete start pulse did not begin a conversion");

  AST_DONE_FLAG_LOW: assert property (sar_done && !start_rise |=> !ctrl_reg.done_n) // RULE_08
    else $error("end of conversion flag not driven low");

  AST_RESULT_LOAD: assert property (sar_done && !start_rise |=> // RULE_09
    result_reg == $past(sar_result))
    else $error("result register missed the conversion outcome");

  AST_OFF_IDLE: assert property (!conv_on |-> !o_analog.power ##1 !sar_busy) // RULE_07
    else $error("converter active while switched off");

  AST_TICK_RATE: assert property (conv_tick && tick_gap_ok_reg |-> // RULE_04
    tick_gap_reg == 8'((`ADCU_DIV_BASE << ctrl_reg.clk_sel) - 1))
    else $error("conversion clock period does not match the rate select");

  AST_PINS_FREE: assert property (!conv_on ##1 !conv_on |-> o_portb_analog_en == 8'h00) // RULE_11
    else $error("port B pin claimed while converter is off");

  AST_PIN_CLAIM: assert property (conv_on && ctrl_reg.chan < 3'h6 ##1 $stable(ctrl_reg) // RULE_03
    |-> o_portb_analog_en[ctrl_reg.chan])
    else $error("selected analog input pin not claimed");

  AST_REF_PINS: assert property (conv_on && !refsel_reg ##1 conv_on |-> // RULE_13
    o_portb_analog_en[7:6] == 2'h3)
    else $error("external reference pins not claimed");

  AST_NO_BUILD: assert property (!ADC_PRESENT |-> !ctrl_reg.enable && !sar_busy) // RULE_12
    else $error("converter runs although it is not built");

  AST_WRITE_ANSWER: assert property (wr_fire |=> o_bvalid)
    else $error("write response not raised after address and data");

endmodule // adcu_top

// ===== adcu_analog_model.sv
// comparator and pin model on the analog side of the converter
`timescale 1ns/1ps
module adcu_analog_model (
  input wire logic i_mclk,
  input wire adcu_pkg::adcu_analog_t i_analog,
  input wire logic [47:0] i_levels,
  output logic o_cmp_above
);
  logic [7:0] vin;
  logic idle_toggle = 1'b0;
  always_ff @(posedge i_mclk) begin
    idle_toggle <= ~idle_toggle;
  end
  always_comb begin
    case (i_analog.chan)
      3'h6: vin = 8'h00;
      3'h7: vin = 8'hFF;
      default: vin = i_levels[i_analog.chan * 8 +: 8];
    endcase
  end
  // a powered-down comparator gives no steady answer, so a stale trial cannot pass
  assign o_cmp_above = i_analog.power ? (vin >= i_analog.dac_code) : idle_toggle;
endmodule // adcu_analog_model

// ===== test_adc_control_unit.sv
// self-checking bench of the converter control: bus traffic, conversions, pin sharing
`timescale 1ns/1ps
`include "adcu_defines.svh"
module test_adc_control_unit;
  localparam logic [7:0] A_REF = {`ADCU_IDX_REFSEL, 2'h0};
  localparam logic [7:0] A_CTRL = {`ADCU_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_RES = {`ADCU_IDX_RESULT, 2'h0};
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] prot = 3'h0;
  logic [47:0] levels = 48'h0;
  logic awready, wready, bvalid, arready, rvalid, cmp_above;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] portb_en;
  adcu_pkg::adcu_analog_t analog;
  adcu_pkg::adcu_analog_t analog_off;
  logic [7:0] portb_off;
  int error_cnt = 0, comparisons = 0, cyc = 0, ctrl_m = 32'h80, ref_m = 1;

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) cyc <= cyc + 1;

  adcu_top #(.ADC_PRESENT(1'b1)) DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(prot),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .i_arprot(prot), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_cmp_above(cmp_above),
    .o_analog(analog), .o_portb_analog_en(portb_en));
  adcu_analog_model PART (.i_mclk(i_mclk), .i_analog(analog), .i_levels(levels),
    .o_cmp_above(cmp_above));
  // the same bus traffic reaches a copy built without the converter
  adcu_top #(.ADC_PRESENT(1'b0)) DUT_OFF (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_awvalid(awvalid), .o_awready(), .i_awaddr(awaddr), .i_awprot(prot),
    .i_wvalid(wvalid), .o_wready(), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(), .i_bready(bready), .o_bresp(), .i_arvalid(arvalid),
    .o_arready(), .i_araddr(araddr), .i_arprot(prot), .o_rvalid(),
    .i_rready(rready), .o_rdata(), .o_rresp(), .i_cmp_above(cmp_above),
    .o_analog(analog_off), .o_portb_analog_en(portb_off));

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t data got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t response got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input int v, input logic [3:0] st);
    logic aw, w;
    @(posedge i_mclk);
    aw = 1'b1;
    w = 1'b1;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'($urandom), 8'(v)};
    wstrb <= st;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge i_mclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_mclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge i_mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge i_mclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // the written control value lands in the model, bit 7 stays the converter's own
  task automatic set_ctrl(input int v);
    wr(A_CTRL, v, 4'h1);
    chk_resp(r, 2'h0);
    ctrl_m = (v & 32'h7F) | (ctrl_m & 32'h80);
  endtask
  task automatic chk_state();
    logic [7:0] p;
    int ch;
    p = 8'h00;
    ch = ctrl_m & 7;
    repeat (2) @(posedge i_mclk);
    if (ctrl_m[6]) begin
      if (ch < 6) p[ch] = 1'b1;
      p[6] = (ref_m == 0) || (ch == 6);
      p[7] = (ref_m == 0) || (ch == 7);
    end
    chk_pins(portb_en, p);
    chk_pins({analog.power, analog.ref_internal, 3'h0, analog.chan},
      {ctrl_m[6], ref_m[0], 3'h0, ctrl_m[2:0]});
    chk_pins(portb_off | 8'(analog_off.power), 8'h00);
  endtask
  task automatic chk_regs();
    rd(A_CTRL);
    chk_data(d, ctrl_m);
    rd(A_REF);
    chk_data(d, ref_m << 6);
  endtask

  task automatic convert(input int ch, input int cs);
    int t0, p, n;
    p = 16 << cs;
    set_ctrl(32'h40 | (cs << 3) | ch);
    set_ctrl(32'h60 | (cs << 3) | ch);
    ctrl_m = ctrl_m | 32'h80;
    rd(A_RES);
    chk_data(d, 32'h0);
    chk_regs();
    set_ctrl(32'h40 | (cs << 3) | ch);
    t0 = cyc;
    chk_state();
    n = 0;
    do begin
      rd(A_CTRL);
      n++;
    end while (d[7] && n < 400);
    ctrl_m = ctrl_m & 32'h7F;
    chk_data(32'((cyc - t0) >= 7 * p - 4 && (cyc - t0) <= 8 * p + 16), 32'h1);
    chk_data(d, ctrl_m);
    rd(A_RES);
    chk_data(d, ch == 6 ? 0 : ch == 7 ? 255 : levels[ch * 8 +: 8]);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge i_mclk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  initial begin
    void'($urandom(32'h7b09a53e));
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    chk_regs();
    rd(A_RES);
    chk_data(d, 32'h0);
    chk_state();
    rd(8'h00);
    chk_resp(r, 2'h2);
    $display("test reset values done");
    wr(8'h04, 32'hFF, 4'hF);
    chk_resp(r, 2'h2);
    wr(A_RES, 32'h5A, 4'h1);
    chk_resp(r, 2'h0);
    wr(A_CTRL, 32'h5F, 4'h0);
    rd(A_RES);
    chk_data(d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      set_ctrl($urandom & 32'hDF);
      ref_m = i & 1;
      wr(A_REF, (ref_m << 6) | 32'h3F, 4'h1);
      chk_regs();
      chk_state();
    end
    $display("test register access done");
    levels <= 48'({$urandom, $urandom});
    for (int ch = 0; ch < 8; ch++) begin
      ref_m = ch & 1;
      wr(A_REF, ref_m << 6, 4'h1);
      convert(ch, ch % 4);
    end
    $display("test conversions done");
    set_ctrl(32'h02);
    set_ctrl(32'h22);
    ctrl_m = ctrl_m | 32'h80;
    set_ctrl(32'h42);
    repeat (300) @(posedge i_mclk);
    chk_regs();
    set_ctrl(32'h62);
    set_ctrl(32'h42);
    repeat (30) @(posedge i_mclk);
    set_ctrl(32'h02);
    repeat (300) @(posedge i_mclk);
    chk_regs();
    chk_state();
    $display("test refused starts done");
    convert(3, 0);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    ctrl_m = 32'h80;
    ref_m = 1;
    chk_regs();
    rd(A_RES);
    chk_data(d, 32'h0);
    chk_state();
    $display("test second reset done");
    results();
  end
endmodule // test_adc_control_unit
